/* inc/seq_regs.vh */
`ifndef SEQ_REGS_VH
`define SEQ_REGS_VH

// instruction fields
`define OPC_HI 31
`define OPC_LO 28
`define LINE_FIRST_BIT 27
`define LINE_LAST_BIT 26
`define IRQ_BIT 24
`define PSB_SET_HI 23
`define PSB_SET_LO 20
`define PSB_CLR_HI 19
`define PSB_CLR_LO 16
`define CNT_HI 11
`define CNT_LO 0
`define CNT3_HI 27
`define CNT3_LO 16
`define SYNC_SUPP_BIT 15
`define SYNC_CODE_HI 3
`define SYNC_CODE_LO 0

// opcodes
`define OP_SKIP 4'h2
`define OP_JUMP 4'h7
`define OP_SYNC 4'h8
`define OP_PSKIP 4'ha

// apb byte offsets
`define REG_CTRL 12'h000
`define REG_START 12'h004
`define REG_INT_STAT 12'h008
`define REG_INT_MASK 12'h00c
`define REG_PC 12'h010
`define REG_SEQ_STAT 12'h014

// int status bits
`define INT_DONE 0
`define INT_ERR 1
`define INT_FSE 2
`define INT_W 3

// reset values and misc
`define ZERO32 32'h0000_0000
`define DWORD_STEP 32'h0000_0004
`define ALIGN_MASK 32'hffff_fffc
`define SYNC_VALID_DEF 16'h7ffe
`define LANES 3'h4

`endif

/* core/byte_skipper.v */
`timescale 1ns/10ps
`include "seq_regs.vh"
module byte_skipper #(
  parameter CW = 12
) (
  input wire mclk,
  input wire rst_b,
  input wire start,
  input wire [CW-1:0] count,
  input wire flush,
  input wire avail,
  output wire pop,
  output wire done
);
  reg busy_q;
  reg [CW-1:0] rem_q;
  reg [1:0] lane_q;
  wire [2:0] room;
  wire [2:0] take;
  wire [2:0] lane_sum;

  // bytes left in the head dword versus bytes still owed
  assign room = `LANES - {1'b0, lane_q};
  assign take = (rem_q < {{(CW-3){1'b0}}, room}) ? rem_q[2:0] : room;
  assign lane_sum = {1'b0, lane_q} + take;
  // a dword is popped only once its last lane is consumed
  assign pop = busy_q && avail && lane_sum[2];
  assign done = !busy_q;

  always @(posedge mclk) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      rem_q <= {CW{1'b0}};
      lane_q <= 2'h0;
    end else if (flush) begin
      busy_q <= 1'b0;
      rem_q <= {CW{1'b0}};
      lane_q <= 2'h0;
    end else if (start) begin
      busy_q <= (count != {CW{1'b0}});
      rem_q <= count;
    end else if (busy_q && avail) begin
      // partial dwords leave the lane pointer mid-word for the next skip
      rem_q <= rem_q - {{(CW-3){1'b0}}, take};
      lane_q <= lane_sum[1:0];
      busy_q <= (rem_q != {{(CW-3){1'b0}}, take});
    end
  end
endmodule // byte_skipper

/* core/int_status.v */
`timescale 1ns/10ps
`include "seq_regs.vh"
module int_status #(
  parameter W = `INT_W
) (
  input wire mclk,
  input wire rst_b,
  input wire [W-1:0] events,
  input wire clr_we,
  input wire mask_we,
  input wire [W-1:0] wdata,
  output reg [W-1:0] stat_q,
  output reg [W-1:0] mask_q,
  output wire irq
);
  always @(posedge mclk) begin
    if (!rst_b) begin
      stat_q <= {W{1'b0}};
      mask_q <= {W{1'b0}};
    end else begin
      // set beats a simultaneous write-one-to-clear
      stat_q <= (stat_q & ~(clr_we ? wdata : {W{1'b0}})) | events;
      if (mask_we) begin
        mask_q <= wdata;
      end
    end
  end

  assign irq = |(stat_q & mask_q);
endmodule // int_status

/* core/dma_sequencer_skip_jump_sync.v */
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "seq_regs.vh"
module dma_sequencer_skip_jump_sync #(
  parameter CW = 12,
  parameter [15:0] SYNC_VALID = `SYNC_VALID_DEF
) (
  input wire mclk,
  input wire rst_b,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // instruction fetch
  output wire fetch_req,
  output wire [31:0] fetch_addr,
  input wire fetch_ack,
  input wire [31:0] fetch_data,
  // fifo discard port
  input wire [2:0] fifo_avail,
  input wire [3:0] fifo_status,
  input wire field_sync_error,
  output wire [2:0] fifo_pop,
  // status
  output wire line_first_flag,
  output wire line_last_flag,
  output wire [3:0] program_status_bits,
  output wire irq
);
  localparam S_IDLE = 3'h0;
  localparam S_FETCH0 = 3'h1;
  localparam S_FETCH1 = 3'h2;
  localparam S_SKIP = 3'h3;
  localparam S_SYNC = 3'h4;
  localparam S_DONE = 3'h5;
  localparam S_HALT = 3'h6;

  function op_known;
    input [3:0] op;
    begin
      op_known = (op == `OP_SKIP) || (op == `OP_PSKIP) ||
                 (op == `OP_JUMP) || (op == `OP_SYNC);
    end
  endfunction

  function op_two_dword;
    input [3:0] op;
    begin
      op_two_dword = (op == `OP_PSKIP) || (op == `OP_JUMP) || (op == `OP_SYNC);
    end
  endfunction

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] pc_q;
  reg [31:0] start_q;
  reg enable_q;
  reg enable_prev_q;
  reg [31:0] ir0_q;
  reg [31:0] ir1_q;
  reg [3:0] psb_q;
  reg [`INT_W-1:0] events;
  reg [2:0] skip_start;
  reg skip_flush;

  wire [3:0] op0;
  wire [3:0] fetch_op;
  wire [3:0] sync_code;
  wire sync_match;
  wire [2:0] skip_pop;
  wire [2:0] skip_done;
  wire [2:0] sync_pop;
  wire wr_en;
  wire rd_en;
  wire map_hit;
  wire [`INT_W-1:0] int_stat;
  wire [`INT_W-1:0] int_mask;
  wire enable_rise;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped offsets answer with pslverr

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign map_hit = (paddr == `REG_CTRL) || (paddr == `REG_START) ||
                   (paddr == `REG_INT_STAT) || (paddr == `REG_INT_MASK) ||
                   (paddr == `REG_PC) || (paddr == `REG_SEQ_STAT);
  assign pslverr = psel && penable && !map_hit;

  always @(posedge mclk) begin
    if (!rst_b) begin
      enable_q <= 1'b0;
      start_q <= `ZERO32;
    end else if (wr_en) begin
      if (paddr == `REG_CTRL) begin
        enable_q <= pwdata[0];
      end
      if (paddr == `REG_START) begin
        start_q <= pwdata & `ALIGN_MASK;
      end
    end
  end

  // read data is registered in the setup cycle so it is stable in the access cycle
  always @(posedge mclk) begin
    if (!rst_b) begin
      prdata <= `ZERO32;
    end else if (rd_en && !penable) begin
      case (paddr)
        `REG_CTRL: prdata <= {31'h0000_0000, enable_q};
        `REG_START: prdata <= start_q;
        `REG_INT_STAT: prdata <= {29'h0000_0000, int_stat};
        `REG_INT_MASK: prdata <= {29'h0000_0000, int_mask};
        `REG_PC: prdata <= pc_q;
        `REG_SEQ_STAT: prdata <= {25'h000_0000, psb_q, state_q};
        default: prdata <= `ZERO32;
      endcase
    end
  end

  int_status #(
    .W(`INT_W)
  ) u_int (
    .mclk(mclk),
    .rst_b(rst_b),
    .events(events),
    .clr_we(wr_en && (paddr == `REG_INT_STAT)),
    .mask_we(wr_en && (paddr == `REG_INT_MASK)),
    .wdata(pwdata[`INT_W-1:0]),
    .stat_q(int_stat),
    .mask_q(int_mask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  assign op0 = ir0_q[`OPC_HI:`OPC_LO];
  assign fetch_op = fetch_data[`OPC_HI:`OPC_LO];
  assign sync_code = ir0_q[`SYNC_CODE_HI:`SYNC_CODE_LO];
  assign sync_match = fifo_avail[0] && (fifo_status == sync_code);
  assign enable_rise = enable_q && !enable_prev_q;
  assign fetch_req = (state_q == S_FETCH0) || (state_q == S_FETCH1);
  assign fetch_addr = pc_q;

  // sync throws away whole dwords from every fifo until the status lines up
  assign sync_pop = (state_q == S_SYNC && !sync_match) ? fifo_avail : 3'h0;
  assign fifo_pop = skip_pop | sync_pop;

  assign line_first_flag = (state_q == S_SKIP) && ir0_q[`LINE_FIRST_BIT];
  assign line_last_flag = (state_q == S_SKIP) && ir0_q[`LINE_LAST_BIT];
  assign program_status_bits = psb_q;

  always @* begin
    state_d = state_q;
    skip_start = 3'h0;
    skip_flush = 1'b0;
    events = {`INT_W{1'b0}};
    case (state_q)
      S_IDLE: begin
        if (enable_rise) begin
          state_d = S_FETCH0;
        end
      end
      S_FETCH0: begin
        if (fetch_ack) begin
          if (!op_known(fetch_op)) begin
            state_d = S_HALT;
            events[`INT_ERR] = 1'b1;
          end else if (op_two_dword(fetch_op)) begin
            state_d = S_FETCH1;
          end else begin
            state_d = S_SKIP;
            skip_start = 3'h1;
          end
        end
      end
      S_FETCH1: begin
        if (fetch_ack) begin
          if (op0 == `OP_PSKIP) begin
            state_d = S_SKIP;
            skip_start = 3'h7;
          end else if (op0 == `OP_JUMP) begin
            state_d = S_DONE;
          end else if (!SYNC_VALID[sync_code]) begin
            state_d = S_HALT;
            events[`INT_ERR] = 1'b1;
          end else begin
            state_d = S_SYNC;
          end
        end
      end
      S_SKIP: begin
        if (&skip_done) begin
          state_d = S_DONE;
        end
      end
      S_SYNC: begin
        events[`INT_FSE] = field_sync_error && !ir0_q[`SYNC_SUPP_BIT];
        if (sync_match) begin
          state_d = S_DONE;
          skip_flush = 1'b1;
        end
      end
      S_DONE: begin
        events[`INT_DONE] = ir0_q[`IRQ_BIT];
        state_d = S_FETCH0;
      end
      S_HALT: begin
        // stays halted until software drops and raises the enable again
        if (!enable_q) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
    if (!enable_q) begin
      state_d = S_IDLE;
    end
  end

  always @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      enable_prev_q <= 1'b0;
      pc_q <= `ZERO32;
      ir0_q <= `ZERO32;
      ir1_q <= `ZERO32;
      psb_q <= 4'h0;
    end else begin
      state_q <= state_d;
      enable_prev_q <= enable_q;
      if (state_q == S_IDLE && enable_rise) begin
        pc_q <= start_q;
      end
      if (state_q == S_FETCH0 && fetch_ack) begin
        ir0_q <= fetch_data;
        pc_q <= pc_q + `DWORD_STEP;
      end
      if (state_q == S_FETCH1 && fetch_ack) begin
        ir1_q <= fetch_data;
        if (op0 == `OP_JUMP) begin
          // low bits are ignored: the target is always a dword address
          pc_q <= fetch_data & `ALIGN_MASK;
        end else begin
          pc_q <= pc_q + `DWORD_STEP;
        end
      end
      if (state_q == S_DONE) begin
        // set wins where a bit is both set and reset
        psb_q <= (psb_q & ~ir0_q[`PSB_CLR_HI:`PSB_CLR_LO]) |
                 ir0_q[`PSB_SET_HI:`PSB_SET_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte skippers, one per fifo; counts come straight off the fetch bus, except the planar luma count, which comes from ir0_q

  byte_skipper #(
    .CW(CW)
  ) u_skip_luma (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(skip_start[0]),
    .count(state_q == S_FETCH1 ? ir0_q[`CNT_HI:`CNT_LO] : fetch_data[`CNT_HI:`CNT_LO]),
    .flush(skip_flush),
    .avail(fifo_avail[0]),
    .pop(skip_pop[0]),
    .done(skip_done[0])
  );

  byte_skipper #(
    .CW(CW)
  ) u_skip_c2 (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(skip_start[1]),
    .count(fetch_data[`CNT_HI:`CNT_LO]),
    .flush(skip_flush),
    .avail(fifo_avail[1]),
    .pop(skip_pop[1]),
    .done(skip_done[1])
  );

  byte_skipper #(
    .CW(CW)
  ) u_skip_c3 (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(skip_start[2]),
    .count(fetch_data[`CNT3_HI:`CNT3_LO]),
    .flush(skip_flush),
    .avail(fifo_avail[2]),
    .pop(skip_pop[2]),
    .done(skip_done[2])
  );
endmodule // dma_sequencer_skip_jump_sync

/* verification/seq_asserts.sv */
`timescale 1ns/10ps
module seq_asserts #(parameter CW = 12, parameter [15:0] SYNC_VALID = 16'h7ffe) (
  input wire mclk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire fetch_req,
  input wire [31:0] fetch_addr,
  input wire fetch_ack,
  input wire [31:0] fetch_data,
  input wire [2:0] fifo_avail,
  input wire [3:0] fifo_status,
  input wire field_sync_error,
  input wire [2:0] fifo_pop,
  input wire line_first_flag,
  input wire line_last_flag,
  input wire [3:0] program_status_bits,
  input wire irq
);
  wire ack = fetch_req && fetch_ack;
  wire [3:0] op = fetch_data[31:28];
  wire two = op == 4'h7 || op == 4'h8 || op == 4'ha;
  logic w1_q, sync_q;
  logic [3:0] op_q, code_q;
  logic [31:0] tgt_q;
  // word tracking breaks if software stops mid-fetch; the bench never does
  always @(posedge mclk) begin
    if (!rst_b) begin
      w1_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      if (ack) w1_q <= !w1_q && two;
      if (ack && !w1_q) op_q <= op;
      if (ack && !w1_q) code_q <= fetch_data[3:0];
      if (ack && w1_q) tgt_q <= fetch_data;
      // an invalid code halts instead of syncing, so it must not arm the tracker
      if (ack && w1_q && op_q == 4'h8 && SYNC_VALID[code_q]) sync_q <= 1'b1;
      else if (sync_q && fifo_avail[0] && fifo_status == code_q) sync_q <= 1'b0;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_first(logic [3:0] o);
    ack && !w1_q && op == o;
  endsequence
  sequence s_target;
    ack && w1_q && op_q == 4'h7;
  endsequence
  property p_pop_avail; (fifo_pop & ~fifo_avail) == 3'b000; endproperty
  property p_hold; fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr); endproperty
  property p_align; fetch_req |-> fetch_addr[1:0] == 2'b00; endproperty
  property p_jump; s_target |=> ##[1:3] fetch_req && fetch_addr == {tgt_q[31:2], 2'b00};
  endproperty
  property p_skip_one; s_first(4'h2) |=> !fetch_req; endproperty
  property p_halt; ack && !w1_q && !two && op != 4'h2 |=> !fetch_req [*6]; endproperty
  property p_sync_pop; sync_q && fifo_avail[0] && fifo_status != code_q |-> fifo_pop == fifo_avail;
  endproperty
  property p_sync_hit; sync_q && fifo_avail[0] && fifo_status == code_q |-> fifo_pop == 3'b000;
  endproperty
  property p_flag; line_first_flag || line_last_flag |-> !fetch_req; endproperty
  a_pop_avail: assert property (p_pop_avail) else $error("pop without data");
  a_hold: assert property (p_hold) else $error("fetch dropped");
  a_align: assert property (p_align) else $error("fetch unaligned");
  a_jump: assert property (p_jump) else $error("jump target missed");
  a_skip_one: assert property (p_skip_one) else $error("skip fetched more");
  a_halt: assert property (p_halt) else $error("no halt");
  a_sync_pop: assert property (p_sync_pop) else $error("sync kept data");
  a_sync_hit: assert property (p_sync_hit) else $error("sync popped on match");
  a_flag: assert property (p_flag) else $error("flag outside skip");
endmodule // seq_asserts
bind dma_sequencer_skip_jump_sync seq_asserts #(.CW(CW), .SYNC_VALID(SYNC_VALID)) u_chk (.*);

/* verification/host_mem.sv */
`timescale 1ns/10ps
module host_mem (
  input wire mclk,
  input wire slow,
  input wire fetch_req,
  input wire [31:0] fetch_addr,
  output logic fetch_ack,
  output logic [31:0] fetch_data
);
  logic [31:0] mem [0:15];
  logic [1:0] wait_q = 2'h0;
  initial fetch_ack = 1'b0;
  initial fetch_data = 32'h0000_0000;
  // idle bus shows a changing pattern so a stale word is never mistaken for data
  always @(posedge mclk) begin
    fetch_ack <= 1'b0;
    fetch_data <= ~fetch_data;
    if (fetch_req && !fetch_ack && slow && wait_q != 2'h2) begin
      wait_q <= wait_q + 2'h1;
    end else if (fetch_req && !fetch_ack) begin
      wait_q <= 2'h0;
      fetch_ack <= 1'b1;
      fetch_data <= mem[fetch_addr[5:2]];
    end
  end
endmodule // host_mem

/* verification/dma_sequencer_skip_jump_sync_test.sv */
`timescale 1ns/10ps
module dma_sequencer_skip_jump_sync_test;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0] fifo_avail = 3'b111;
  logic [3:0] fifo_status = 4'h3;
  logic field_sync_error = 1'b1;
  wire [31:0] prdata, fetch_addr, fetch_data;
  wire pready, pslverr, fetch_req, fetch_ack, line_first_flag, line_last_flag, irq;
  wire [2:0] fifo_pop;
  wire [3:0] program_status_bits;
  int errors = 0, check_count = 0, n0 = 0, n1 = 0, n2 = 0, s0 = -1, s1 = -1, s2 = -1;
  logic both = 1'b0;
  logic err;
  logic [31:0] rd;
  always #25 mclk = ~mclk;
  dma_sequencer_skip_jump_sync dut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data), .fifo_avail(fifo_avail),
    .fifo_status(fifo_status), .field_sync_error(field_sync_error), .fifo_pop(fifo_pop),
    .line_first_flag(line_first_flag), .line_last_flag(line_last_flag),
    .program_status_bits(program_status_bits), .irq(irq));
  host_mem u_mem (.mclk(mclk), .slow(slow), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data));
  ////////////////////////////////////////
  // fifo head status turns to code 5 once four luma words are gone
  always @(posedge mclk) begin
    n0 <= n0 + fifo_pop[0];
    n1 <= n1 + fifo_pop[1];
    n2 <= n2 + fifo_pop[2];
    if (fifo_pop[0] && n0 >= 3) fifo_status <= 4'h5;
    if (line_first_flag && line_last_flag) both <= 1'b1;
    if (fetch_req && fetch_addr == 32'h0000_0020) begin
      s0 <= n0;
      s1 <= n1;
      s2 <= n2;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (n == 20) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_halt;
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[2:0] !== 3'h6 && k < 60) begin
      k++;
      apb(1'b0, 12'h014, 32'h0);
    end
    chk({29'h0, rd[2:0]}, 32'h6);
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h020, 32'h1);
    chk({31'h0, err}, 32'h1);
    $display("regs test done");
  endtask
  task automatic t_prog_a;
    u_mem.mem[0] = 32'h2d10_0005;
    u_mem.mem[1] = 32'ha001_0003;
    u_mem.mem[2] = 32'h0008_0004;
    u_mem.mem[3] = 32'h7020_0000;
    u_mem.mem[4] = 32'h0000_0020;
    u_mem.mem[8] = 32'h8000_8005;
    u_mem.mem[9] = 32'h0000_0000;
    u_mem.mem[10] = 32'hf000_0000;
    u_mem.mem[12] = 32'h8000_0005;
    u_mem.mem[13] = 32'h0000_0000;
    u_mem.mem[14] = 32'h8000_0000;
    u_mem.mem[15] = 32'h0000_0000;
    apb(1'b1, 12'h00c, 32'h7);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    wait_halt;
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h3);
    chk({31'h0, irq}, 32'h1);
    chk({28'h0, program_status_bits}, 32'h2);
    chk(s0, 32'h2);
    chk({s1[15:0], s2[15:0]}, 32'h0001_0002);
    chk(n0, 32'h4);
    chk({31'h0, both}, 32'h1);
    apb(1'b1, 12'h008, 32'h7);
    apb(1'b0, 12'h008, 32'h0);
    chk({rd[30:0], irq}, 32'h0);
    $display("program a test done");
  endtask
  task automatic t_prog_b;
    slow <= 1'b1;
    u_mem.mem[5] = 32'ha000_0004;
    u_mem.mem[6] = 32'h0000_0000;
    u_mem.mem[7] = 32'h2000_0008;
    u_mem.mem[8] = 32'h7000_0000;
    u_mem.mem[9] = 32'h0000_0030;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h14);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h14);
    apb(1'b1, 12'h000, 32'h1);
    wait_halt;
    // a packed skip right after a planar one must use its own count
    chk(n0, 32'h7);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, 12'h00c, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("program b test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_regs;
    t_prog_a;
    t_prog_b;
    final_report;
  end
  initial begin
    repeat (4000) @(posedge mclk);
    errors++;
    final_report;
  end
endmodule // dma_sequencer_skip_jump_sync_test
